// ===== common/wakeup_flags_cfg.svh
// constants for the internal module wakeup flag register block
`ifndef WAKEUP_FLAGS_CFG_SVH
`define WAKEUP_FLAGS_CFG_SVH
// =====================================================================
// register map
`define FLAGS_OFFSET     8'h07
`define ENABLE_OFFSET    8'h04
`define MODE_OFFSET      8'h05
// =====================================================================
// reset values
`define FLAGS_RESET      8'h00
`define ENABLE_RESET     8'h00
`define MODE_RESET       2'h0
`define RDATA_RESET      8'h00
// =====================================================================
// field positions and module count
`define MODE_DEEP_BIT    0
`define MODE_STOP_BIT    1
`define NUM_MODULES      8
`endif

// ===== common/wakeup_flags_pkg.sv
// types for the internal module wakeup flag register block
package wakeup_flags_pkg;
   typedef enum logic [1:0] {
      PH_RUN,
      PH_STOP,
      PH_EXIT
   } power_phase_e;
   typedef logic [7:0] byte_t;
endpackage

// ===== hw/wakeup_flag_cell.sv
// one module wakeup flag: captured cause mirrored from the peripheral flag
`timescale 1ns/1ns
module wakeup_flag_cell (
   input  wire logic i_ref_clk,
   input  wire logic i_rstn,
   input  wire logic i_enable,
   input  wire logic i_capture,
   input  wire logic i_periph_flag,
   output logic      o_flag
);
   typedef struct packed {
      logic flag;
   } cell_s;
   cell_s state_reg;
   cell_s state_next;

   // =====================================================================
   // next state
   always_comb begin
      state_next = state_reg;
      // set only by an enabled module that caused the exit [RL5] [RL7]
      if (i_capture && i_enable && i_periph_flag) begin
         state_next.flag = 1'b1;
      end else if (!i_periph_flag) begin
         // outside reset, falls only when the peripheral clears its own flag [RL4]
         state_next.flag = 1'b0;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign o_flag = state_reg.flag;

   property p_clear_follows;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      !i_periph_flag |=> !o_flag;
   endproperty
   a_clear_follows: assert property (p_clear_follows) // [RL4]
      else $error("flag did not follow peripheral clear");

   property p_no_set_when_disabled;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      !o_flag && !i_enable |=> !o_flag;
   endproperty
   a_no_set_when_disabled: assert property (p_no_set_when_disabled) // [RL7]
      else $error("disabled module set its flag");
endmodule // wakeup_flag_cell

// ===== hw/internal_wakeup_flag_register.sv
// register bank holding the internal module wakeup flags and their enables
//
// Functional notes
// RL1: eight flags in bits 7..0, one reads 1 when its module caused the exit.
// RL2: shallow stop flags interrupt source; deep stop flags reset-flow source.
// RL3: each flag is a direct view of its peripheral's own wakeup flag; here a registered copy, set only at the stop exit capture.
// RL4: writing 1 does not clear; flag falls when the peripheral clears it.
// RL5: flag sets only if module was enabled and actually caused the exit.
// RL6: cleared only by the chip reset excluding deep stop; kept otherwise.
// RL7: a module wakes the chip only when its wakeup enable bit is set.
//
// Local design decision: the strobed register port.
`timescale 1ns/1ns
`include "wakeup_flags_cfg.svh"
module internal_wakeup_flag_register
   import wakeup_flags_pkg::*;
#(
   parameter int NUM_MODULES = `NUM_MODULES
) (
   input  wire logic       i_ref_clk,
   input  wire logic       i_rstn,
   input  wire logic [7:0] i_addr,
   input  wire logic [7:0] i_wdata,
   input  wire logic       i_wr,
   input  wire logic       i_rd,
   input  wire logic [7:0] i_periph_flag,
   input  wire logic       i_stop_entry,
   input  wire logic       i_deep_stop,
   input  wire logic       i_wake_exit,
   output logic [7:0]      o_rdata,
   output logic            o_wake_irq,
   output logic            o_wake_reset
);
   // the flag byte and its bit map are fixed at eight modules
   if (NUM_MODULES != 8) begin : g_bad_count
      $error("only eight wakeup modules supported");
   end

   typedef struct packed {
      byte_t        enable;
      logic [1:0]   mode;
      power_phase_e phase;
      byte_t        rdata;
      logic         irq;
      logic         rst;
   } bank_s;
   bank_s state_reg;
   bank_s state_next;
   logic [7:0] flags;
   logic       capture;

   // capture the cause only at the moment the stop mode is left
   assign capture = (state_reg.phase == PH_STOP) && i_wake_exit;

   // =====================================================================
   // per-module flags
   genvar g;
   generate
      for (g = 0; g < NUM_MODULES; g++) begin : g_flag
         wakeup_flag_cell u_cell (
            .i_ref_clk     (i_ref_clk),
            .i_rstn        (i_rstn),
            .i_enable      (state_reg.enable[g]),
            .i_capture     (capture),
            .i_periph_flag (i_periph_flag[g]),
            .o_flag        (flags[g])
         ); // [RL1] [RL3]

         property p_set_cause;
            @(posedge i_ref_clk) disable iff (!i_rstn)
            $rose(flags[g]) |-> $past(capture && state_reg.enable[g] && i_periph_flag[g]);
         endproperty
         a_set_cause: assert property (p_set_cause) // [RL5]
            else $error("flag set without enabled exit");

         property p_flag_kept;
            @(posedge i_ref_clk) disable iff (!i_rstn)
            flags[g] && i_periph_flag[g] |=> flags[g];
         endproperty
         a_flag_kept: assert property (p_flag_kept) // [RL4]
            else $error("flag fell while peripheral flag held");

         property p_disabled_bit;
            @(posedge i_ref_clk) disable iff (!i_rstn)
            !state_reg.enable[g] && !flags[g] |=> !flags[g];
         endproperty
         a_disabled_bit: assert property (p_disabled_bit) // [RL7]
            else $error("disabled module raised its flag");
      end
   endgenerate

   // =====================================================================
   // next state
   always_comb begin
      state_next     = state_reg;
      state_next.irq = 1'b0;
      state_next.rst = 1'b0;
      state_next.rdata = `RDATA_RESET;
      if (i_wr && i_addr == `ENABLE_OFFSET) begin
         state_next.enable = i_wdata;
      end
      // writes to the flag offset are ignored on purpose [RL4]
      if (i_rd) begin
         case (i_addr)
            `FLAGS_OFFSET:  state_next.rdata = flags; // [RL1]
            `ENABLE_OFFSET: state_next.rdata = state_reg.enable;
            `MODE_OFFSET:   state_next.rdata = {6'h00, state_reg.mode};
            default:        state_next.rdata = `RDATA_RESET;
         endcase
      end
      case (state_reg.phase)
         PH_RUN: begin
            if (i_stop_entry) begin
               state_next.phase = PH_STOP;
               state_next.mode  = {1'b1, i_deep_stop};
            end
         end
         PH_STOP: begin
            if (i_wake_exit) begin
               state_next.phase = PH_EXIT;
               // shallow stop resumes by interrupt, deep stop by reset [RL2]
               if (state_reg.mode[`MODE_DEEP_BIT]) begin
                  state_next.rst = |(i_periph_flag & state_reg.enable);
               end else begin
                  state_next.irq = |(i_periph_flag & state_reg.enable);
               end
            end
         end
         PH_EXIT: begin
            state_next.phase = PH_RUN;
            state_next.mode[`MODE_STOP_BIT] = 1'b0;
         end
         default: state_next.phase = PH_RUN;
      endcase
   end

   // i_rstn is the chip reset excluding deep stop; other resets never reach here
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         state_reg <= '{enable: `ENABLE_RESET, mode: `MODE_RESET, phase: PH_RUN,
                        rdata: `RDATA_RESET, irq: 1'b0, rst: 1'b0}; // [RL6]
      end else begin
         state_reg <= state_next;
      end
   end

   assign o_rdata      = state_reg.rdata;
   assign o_wake_irq   = state_reg.irq;
   assign o_wake_reset = state_reg.rst;

   // =====================================================================
   // checks
   property p_read_flags;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      i_rd && i_addr == `FLAGS_OFFSET |=> o_rdata == $past(flags);
   endproperty
   a_read_flags: assert property (p_read_flags) // [RL1]
      else $error("flag read data wrong");

   property p_mirror;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      1'b1 |-> (flags & ~i_periph_flag & ~$past(i_periph_flag)) == 8'h00;
   endproperty
   a_mirror: assert property (p_mirror) // [RL3]
      else $error("flag set while peripheral flag clear");

   property p_write_no_clear;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      i_wr && i_addr == `FLAGS_OFFSET && !capture && flags != 8'h00
         && (i_periph_flag & flags) == flags |=> (flags & $past(flags)) == $past(flags);
   endproperty
   a_write_no_clear: assert property (p_write_no_clear) // [RL4]
      else $error("write cleared a flag");

   property p_no_flag_without_exit;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      !capture |=> (flags & ~$past(flags)) == 8'h00;
   endproperty
   a_no_flag_without_exit: assert property (p_no_flag_without_exit) // [RL5]
      else $error("flag rose outside a stop exit");

   property p_irq_shallow;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      o_wake_irq |-> !$past(state_reg.mode[`MODE_DEEP_BIT]) && !o_wake_reset;
   endproperty
   a_irq_shallow: assert property (p_irq_shallow) // [RL2]
      else $error("interrupt flow from deep stop");

   property p_reset_deep;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      o_wake_reset |-> $past(state_reg.mode[`MODE_DEEP_BIT]);
   endproperty
   a_reset_deep: assert property (p_reset_deep) // [RL2]
      else $error("reset flow from shallow stop");

   property p_disabled_quiet;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      state_reg.enable == 8'h00 && flags == 8'h00 |=> flags == 8'h00;
   endproperty
   a_disabled_quiet: assert property (p_disabled_quiet) // [RL7]
      else $error("flag set with all enables clear");

   property p_reset_zero;
      @(posedge i_ref_clk)
      $rose(i_rstn) |-> flags == 8'h00 && state_reg.enable == 8'h00;
   endproperty
   a_reset_zero: assert property (p_reset_zero) // [RL6]
      else $error("not zero after reset");

   // =====================================================================
   // read path and enable register write checks
   property p_rdata_idle;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      !i_rd |=> o_rdata == `RDATA_RESET;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) // [RL1]
      else $error("read data did not return to zero");

   property p_read_enable;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      i_rd && i_addr == `ENABLE_OFFSET |=> o_rdata == $past(state_reg.enable);
   endproperty
   a_read_enable: assert property (p_read_enable) // [RL7]
      else $error("enable read data wrong");

   property p_read_mode;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      i_rd && i_addr == `MODE_OFFSET |=> o_rdata == {6'h00, $past(state_reg.mode)};
   endproperty
   a_read_mode: assert property (p_read_mode) // [RL2]
      else $error("mode read data wrong");

   property p_read_unmapped;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      i_rd && i_addr != `FLAGS_OFFSET && i_addr != `ENABLE_OFFSET
         && i_addr != `MODE_OFFSET |=> o_rdata == `RDATA_RESET;
   endproperty
   a_read_unmapped: assert property (p_read_unmapped) // [RL1]
      else $error("unmapped read not zero");

   property p_enable_write;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      i_wr && i_addr == `ENABLE_OFFSET |=> state_reg.enable == $past(i_wdata);
   endproperty
   a_enable_write: assert property (p_enable_write) // [RL7]
      else $error("enable write lost");

   property p_enable_hold;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      !(i_wr && i_addr == `ENABLE_OFFSET) |=> $stable(state_reg.enable);
   endproperty
   a_enable_hold: assert property (p_enable_hold) // [RL7]
      else $error("enable changed without a write");

   // =====================================================================
   // power phase checks
   // a flow pulse longer than one cycle would start the wake handling twice
   property p_irq_pulse;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      o_wake_irq |=> !o_wake_irq;
   endproperty
   a_irq_pulse: assert property (p_irq_pulse) // [RL2]
      else $error("interrupt flow pulse too long");

   property p_reset_pulse;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      o_wake_reset |=> !o_wake_reset;
   endproperty
   a_reset_pulse: assert property (p_reset_pulse) // [RL2]
      else $error("reset flow pulse too long");

   property p_one_flow;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      capture && (i_periph_flag & state_reg.enable) != 8'h00
         |=> o_wake_irq != o_wake_reset;
   endproperty
   a_one_flow: assert property (p_one_flow) // [RL2]
      else $error("enabled wake did not start exactly one flow");

   property p_flow_needs_exit;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      o_wake_irq || o_wake_reset |-> $past(capture);
   endproperty
   a_flow_needs_exit: assert property (p_flow_needs_exit) // [RL5]
      else $error("wake flow without a stop exit");

   property p_mode_on_entry;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      state_reg.phase == PH_RUN && i_stop_entry
         |=> state_reg.phase == PH_STOP && state_reg.mode == {1'b1, $past(i_deep_stop)};
   endproperty
   a_mode_on_entry: assert property (p_mode_on_entry) // [RL2]
      else $error("stop depth not taken on entry");

   property p_stop_hold;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      state_reg.phase == PH_STOP && !i_wake_exit
         |=> state_reg.phase == PH_STOP && $stable(state_reg.mode);
   endproperty
   a_stop_hold: assert property (p_stop_hold) // [RL2]
      else $error("stop left without an exit");

   property p_exit_to_run;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      state_reg.phase == PH_EXIT
         |=> state_reg.phase == PH_RUN && !state_reg.mode[`MODE_STOP_BIT];
   endproperty
   a_exit_to_run: assert property (p_exit_to_run) // [RL2]
      else $error("exit did not return to run");

   property p_quiet_outside_stop;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      state_reg.phase != PH_STOP |=> !o_wake_irq && !o_wake_reset;
   endproperty
   a_quiet_outside_stop: assert property (p_quiet_outside_stop) // [RL2]
      else $error("wake flow outside a stop exit");
endmodule // internal_wakeup_flag_register

// ===== bench/periph_model.sv
// behavioural model of the eight internal peripherals and their wakeup flags
`timescale 1ns/1ns
module periph_model (
   input  wire logic       i_ref_clk,
   input  wire logic       i_rstn,
   input  wire logic [7:0] i_set,
   input  wire logic [7:0] i_clr,
   output logic [7:0]      o_flag
);
   // =====================================================================
   // peripheral flags
   // flags only fall through the peripheral's own clear, never via the register bank
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_flag <= 8'h00;
      end else begin
         o_flag <= (o_flag | i_set) & ~i_clr;
      end
   end
endmodule // periph_model

// ===== bench/tb_top.sv
// self-checking bench for the internal module wakeup flag register
`timescale 1ns/1ns
`include "wakeup_flags_cfg.svh"
`define CHK(a, e, m) begin total_checks++; if ((a) !== (e)) begin error_cnt++; \
   $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, a, e); end end
module tb_top;
   import wakeup_flags_pkg::*;
   logic  i_ref_clk = 1'b0;
   logic  i_rstn    = 1'b0;
   logic  p_rstn    = 1'b0;
   logic  i_wr = 1'b0, i_rd = 1'b0, i_stop_entry = 1'b0, i_deep_stop = 1'b0;
   logic  i_wake_exit = 1'b0;
   byte_t i_addr = 8'h00, i_wdata = 8'h00, p_set = 8'h00, p_clr = 8'h00;
   byte_t periph_flag, o_rdata;
   logic  o_wake_irq, o_wake_reset;
   int    error_cnt = 0;
   int    total_checks = 0;
   always #5 i_ref_clk = ~i_ref_clk;
   periph_model u_periph (.i_ref_clk(i_ref_clk), .i_rstn(p_rstn), .i_set(p_set),
      .i_clr(p_clr), .o_flag(periph_flag));
   internal_wakeup_flag_register u_dut (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
      .i_periph_flag(periph_flag), .i_stop_entry(i_stop_entry),
      .i_deep_stop(i_deep_stop), .i_wake_exit(i_wake_exit), .o_rdata(o_rdata),
      .o_wake_irq(o_wake_irq), .o_wake_reset(o_wake_reset));
   // =====================================================================
   // bus and stimulus tasks
   task automatic wr(input byte_t a, input byte_t d);
      @(posedge i_ref_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_ref_clk);
      i_wr <= 1'b0;
   endtask
   task automatic rd_chk(input byte_t a, input byte_t e, input string m);
      @(posedge i_ref_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_ref_clk);
      i_rd <= 1'b0;
      #1;
      `CHK(o_rdata, e, m)
   endtask
   task automatic periph(input byte_t s, input byte_t c);
      @(posedge i_ref_clk);
      p_set <= s;
      p_clr <= c;
      @(posedge i_ref_clk);
      p_set <= 8'h00;
      p_clr <= 8'h00;
   endtask
   // stop entry, mode readback in stop, exit, then the one-cycle wake pulse
   task automatic wake(input logic deep);
      @(posedge i_ref_clk);
      i_deep_stop <= deep;
      i_stop_entry <= 1'b1;
      @(posedge i_ref_clk);
      i_stop_entry <= 1'b0;
      rd_chk(`MODE_OFFSET, {6'h00, 1'b1, deep}, "mode in stop");
      @(posedge i_ref_clk);
      i_wake_exit <= 1'b1;
      @(posedge i_ref_clk);
      i_wake_exit <= 1'b0;
      #1;
      `CHK(o_wake_irq, ~deep, "interrupt flow")
      `CHK(o_wake_reset, deep, "reset flow")
      @(posedge i_ref_clk);
      #1;
      `CHK(o_wake_irq, 1'b0, "interrupt pulse width")
      `CHK(o_wake_reset, 1'b0, "reset pulse width")
      rd_chk(`MODE_OFFSET, {7'h00, deep}, "mode after exit");
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // =====================================================================
   // scenarios
   task automatic t_reset();
      rd_chk(`FLAGS_OFFSET, `FLAGS_RESET, "flags reset");
      rd_chk(`ENABLE_OFFSET, `ENABLE_RESET, "enable reset");
      rd_chk(8'h3c, 8'h00, "unmapped");
      $display("test reset done");
   endtask
   task automatic t_shallow();
      periph(8'h28, 8'h00);
      wr(`ENABLE_OFFSET, 8'h08);
      rd_chk(`ENABLE_OFFSET, 8'h08, "enable readback");
      wake(1'b0);
      rd_chk(`FLAGS_OFFSET, 8'h08, "enabled cause only");
      @(posedge i_ref_clk);
      #1;
      `CHK(o_rdata, `RDATA_RESET, "read data one cycle")
      wr(`FLAGS_OFFSET, 8'hff);
      rd_chk(`FLAGS_OFFSET, 8'h08, "write one kept");
      periph(8'h00, 8'h08);
      rd_chk(`FLAGS_OFFSET, 8'h00, "peripheral clear");
      $display("test shallow done");
   endtask
   task automatic t_deep();
      wr(`ENABLE_OFFSET, 8'hff);
      periph(8'h81, 8'h20);
      wake(1'b1);
      rd_chk(`FLAGS_OFFSET, 8'h81, "deep causes");
      periph(8'h04, 8'h80);
      rd_chk(`FLAGS_OFFSET, 8'h01, "mirror, no wake");
      $display("test deep done");
   endtask
   task automatic t_chip_reset();
      @(posedge i_ref_clk);
      i_rstn <= 1'b0;
      @(posedge i_ref_clk);
      i_rstn <= 1'b1;
      rd_chk(`FLAGS_OFFSET, 8'h00, "chip reset clears");
      rd_chk(`ENABLE_OFFSET, `ENABLE_RESET, "enable after chip reset");
      rd_chk(`MODE_OFFSET, {6'h00, `MODE_RESET}, "mode after chip reset");
      $display("test chip reset done");
   endtask
   initial begin
      repeat (5) @(posedge i_ref_clk);
      i_rstn <= 1'b1;
      p_rstn <= 1'b1;
      t_reset();
      t_shallow();
      t_deep();
      t_chip_reset();
      results();
   end
   // whole run is under a hundred cycles; cut a hang short well beyond that
   initial begin
      #50000;
      error_cnt++;
      results();
   end
endmodule // tb_top
